/* logic/udi_pkg.sv */
// shared constants of the block
`default_nettype none
package udi_pkg;
  // axi4-lite geometry
  localparam int AXI_AW = 8;             // byte address width
  localparam int AXI_DW = 32;            // data width
  localparam int AXI_SW = 4;             // strobe width
  localparam logic [1:0] RESP_OKAY = 2'h0;   // normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

  // register byte addresses
  localparam logic [AXI_AW-1:0] OFS_INT_STATUS = 8'h18;   // w1c event status
  localparam logic [AXI_AW-1:0] OFS_DMA_MASK = 8'h54;     // dma reason mask
  localparam logic [AXI_AW-1:0] OFS_DMA_EP_SEL = 8'h58;   // dma endpoint select
  localparam logic [AXI_AW-1:0] OFS_ALERT_STATUS = 8'h5c; // read-clear alerts
  localparam logic [AXI_AW-1:0] OFS_ALERT_MASK = 8'h60;   // alert mask

  // interrupt status layout
  localparam int STAT_W = 32;
  localparam int BIT_BUS_RESET = 0;
  localparam int BIT_SOF = 1;
  localparam int BIT_PSEUDO_FRAME_FLAG = 2;
  localparam int BIT_SUSPEND = 3;
  localparam int BIT_RESUME = 4;
  localparam int BIT_HS_CHANGE = 5;
  localparam int BIT_DMA = 6;
  localparam int BIT_SETUP = 8;
  localparam int BIT_EP_BASE = 10;       // ep n receive at base+2n, transmit one above
  localparam int NUM_EP = 8;
  localparam logic [STAT_W-1:0] STAT_IMPL = 32'h03ff_fd7f; // implemented bits
  localparam logic [STAT_W-1:0] STAT_RESET = 32'h0000_0000;

  // dma reason mask layout
  localparam int DMA_MASK_W = 16;
  localparam logic [DMA_MASK_W-1:0] DMA_MASK_IMPL = 16'h1ffe;
  localparam logic [DMA_MASK_W-1:0] DMA_MASK_RESET = 16'h0000;

  // dma endpoint select layout
  localparam int EPSEL_W = 8;
  localparam int EPSEL_DIR_BIT = 0;
  localparam int EPSEL_NUM_LSB = 1;
  localparam int EPSEL_NUM_W = 3;
  localparam logic [EPSEL_W-1:0] EPSEL_IMPL = 8'h0f;
  localparam logic [EPSEL_W-1:0] EPSEL_RESET = 8'h00;

  // alert status layout
  localparam int ALERT_W = 2;
  localparam int ALERT_CLASH = 0;        // dma and index point at one endpoint
  localparam int ALERT_BUS_RESET = 1;    // bus reset seen
  localparam logic [ALERT_W-1:0] ALERT_RESET = 2'h0;

  // frame timing
  localparam int CLK_HZ = 25_000_000;
  localparam int FS_FRAME_MS = 1;        // full speed frame period
  localparam int HS_FRAME_US = 125;      // high speed microframe period
  localparam int FS_FRAME_CYCLES = CLK_HZ / 1000 * FS_FRAME_MS;
  localparam int HS_FRAME_CYCLES = CLK_HZ / 1_000_000 * HS_FRAME_US;
  localparam int FRAME_CNT_W = 15;
endpackage
`default_nettype wire

/* logic/udi_pframe_gen.sv */
`timescale 1ns/10ps
`default_nettype none
// pseudo frame tick, restarted by every received frame marker
module udi_pframe_gen #(
  parameter int FS_CYCLES = udi_pkg::FS_FRAME_CYCLES,
  parameter int HS_CYCLES = udi_pkg::HS_FRAME_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_reset_evt,
  input wire logic sof_evt,
  input wire logic hs_mode,
  output logic pseudo_frame_flag_tick
);
  logic [udi_pkg::FRAME_CNT_W-1:0] count_r; // cycles since last frame
  logic [udi_pkg::FRAME_CNT_W-1:0] last_cnt; // terminal count for speed
  logic wrap; // period elapsed without a marker

  // speed picks the period
  assign last_cnt = hs_mode ? udi_pkg::FRAME_CNT_W'(HS_CYCLES - 1)
                            : udi_pkg::FRAME_CNT_W'(FS_CYCLES - 1);
  assign wrap = (count_r >= last_cnt);

  // counter and tick
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_reset_evt) begin
      count_r <= '0;
      pseudo_frame_flag_tick <= 1'b0;
    end else if (sof_evt) begin
      count_r <= '0;
      pseudo_frame_flag_tick <= 1'b1;
    end else begin
      count_r <= wrap ? '0 : count_r + 1'b1;
      pseudo_frame_flag_tick <= wrap;
    end
  end
endmodule // udi_pframe_gen
`default_nettype wire

/* logic/udi_irq_dma_sel.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module udi_irq_dma_sel #(
  parameter int FS_CYCLES = udi_pkg::FS_FRAME_CYCLES,
  parameter int HS_CYCLES = udi_pkg::HS_FRAME_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [udi_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [udi_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [udi_pkg::AXI_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [udi_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [udi_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // usb core event pulses and speed level
  input wire logic bus_reset_evt,
  input wire logic sof_evt,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  input wire logic hs_mode,
  input wire logic control_setup_evt,
  input wire logic [udi_pkg::NUM_EP-1:0] ep_transmit_evt,
  input wire logic [udi_pkg::NUM_EP-1:0] ep_receive_evt,
  // dma reason flags and engine state
  input wire logic [udi_pkg::DMA_MASK_W-1:0] dma_reason_flags,
  input wire logic dma_active,
  input wire logic [udi_pkg::EPSEL_NUM_W-1:0] ep_index_number,
  // outputs
  output logic irq_out,
  output logic alert_irq,
  output logic [udi_pkg::EPSEL_NUM_W-1:0] dma_ep_number,
  output logic dma_direction,
  output logic [udi_pkg::NUM_EP-1:0] dma_receive_buf_sel,
  output logic [udi_pkg::NUM_EP-1:0] dma_transmit_buf_sel
);

  // address match, used by both read and write decode
  function automatic logic addr_is(input logic [udi_pkg::AXI_AW-1:0] addr,
                                   input logic [udi_pkg::AXI_AW-1:0] ofs);
    addr_is = (addr[udi_pkg::AXI_AW-1:2] == ofs[udi_pkg::AXI_AW-1:2]);
  endfunction

  // registers
  logic [udi_pkg::STAT_W-1:0] int_status_r; // w1c event status
  logic [udi_pkg::STAT_W-1:0] int_status_nxt;
  logic [udi_pkg::DMA_MASK_W-1:0] dma_irq_mask_r; // dma reason enables
  logic [udi_pkg::DMA_MASK_W-1:0] dma_irq_mask_nxt;
  logic [udi_pkg::EPSEL_W-1:0] dma_endpoint_select_r; // endpoint and direction
  logic [udi_pkg::EPSEL_W-1:0] dma_endpoint_select_nxt;
  logic [udi_pkg::ALERT_W-1:0] alert_status_r; // read-clear alerts
  logic [udi_pkg::ALERT_W-1:0] alert_status_nxt;
  logic [udi_pkg::ALERT_W-1:0] alert_mask_r; // alert enables
  logic [udi_pkg::ALERT_W-1:0] alert_mask_nxt;

  // event history
  logic [udi_pkg::DMA_MASK_W-1:0] dma_masked_prev_r; // enabled flags last cycle
  logic hs_mode_prev_r; // speed last cycle
  logic clash_prev_r; // endpoint clash last cycle

  // bus slave state
  logic aw_full_r; // write address held
  logic w_full_r; // write data held
  logic [udi_pkg::AXI_AW-1:0] aw_addr_r; // held write address
  logic [udi_pkg::AXI_DW-1:0] w_data_r; // held write data
  logic [udi_pkg::AXI_SW-1:0] w_strb_r; // held strobes

  // handshakes
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;

  // write fires once both halves are held and no response is pending
  wire wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;

  // write decode
  wire wr_status = wr_fire & addr_is(aw_addr_r, udi_pkg::OFS_INT_STATUS);
  wire wr_mask = wr_fire & addr_is(aw_addr_r, udi_pkg::OFS_DMA_MASK);
  wire wr_epsel = wr_fire & addr_is(aw_addr_r, udi_pkg::OFS_DMA_EP_SEL);
  wire wr_alert = wr_fire & addr_is(aw_addr_r, udi_pkg::OFS_ALERT_STATUS);
  wire wr_amask = wr_fire & addr_is(aw_addr_r, udi_pkg::OFS_ALERT_MASK);
  wire wr_hit = wr_status | wr_mask | wr_epsel | wr_alert | wr_amask;

  // read decode
  wire rd_status = addr_is(s_axi_araddr, udi_pkg::OFS_INT_STATUS);
  wire rd_mask = addr_is(s_axi_araddr, udi_pkg::OFS_DMA_MASK);
  wire rd_epsel = addr_is(s_axi_araddr, udi_pkg::OFS_DMA_EP_SEL);
  wire rd_alert = addr_is(s_axi_araddr, udi_pkg::OFS_ALERT_STATUS);
  wire rd_amask = addr_is(s_axi_araddr, udi_pkg::OFS_ALERT_MASK);
  wire rd_hit = rd_status | rd_mask | rd_epsel | rd_alert | rd_amask;

  // byte strobes widened to a bit mask
  logic [udi_pkg::AXI_DW-1:0] strb_bits;
  genvar gb;
  generate
    for (gb = 0; gb < udi_pkg::AXI_SW; gb++) begin : g_strb
      assign strb_bits[gb*8 +: 8] = {8{w_strb_r[gb]}};
    end
  endgenerate
  wire [udi_pkg::AXI_DW-1:0] wbits = w_data_r & strb_bits; // ones written

  // pseudo frame generator
  logic pseudo_frame_flag_tick; // one-cycle pseudo frame pulse
  udi_pframe_gen #(
    .FS_CYCLES(FS_CYCLES),
    .HS_CYCLES(HS_CYCLES)
  ) u_pframe (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus_reset_evt(bus_reset_evt),
    .sof_evt(sof_evt),
    .hs_mode(hs_mode),
    .pseudo_frame_flag_tick(pseudo_frame_flag_tick)
  );

  // event set vector
  logic [udi_pkg::STAT_W-1:0] set_vec; // hardware sets this cycle
  wire [udi_pkg::DMA_MASK_W-1:0] dma_masked = dma_reason_flags & dma_irq_mask_r;
  wire dma_summary_set = |(dma_masked & ~dma_masked_prev_r);
  wire hs_set = hs_mode & ~hs_mode_prev_r & ~suspend_evt;

  // bus event positions
  assign set_vec[udi_pkg::BIT_BUS_RESET] = bus_reset_evt;
  assign set_vec[udi_pkg::BIT_SOF] = sof_evt;
  assign set_vec[udi_pkg::BIT_PSEUDO_FRAME_FLAG] = pseudo_frame_flag_tick;
  assign set_vec[udi_pkg::BIT_SUSPEND] = suspend_evt;
  assign set_vec[udi_pkg::BIT_RESUME] = resume_evt;
  assign set_vec[udi_pkg::BIT_HS_CHANGE] = hs_set;
  assign set_vec[udi_pkg::BIT_DMA] = dma_summary_set;
  assign set_vec[udi_pkg::BIT_DMA+1] = 1'b0; // reserved
  assign set_vec[udi_pkg::BIT_SETUP] = control_setup_evt;
  assign set_vec[udi_pkg::BIT_SETUP+1] = 1'b0; // reserved
  assign set_vec[udi_pkg::STAT_W-1:udi_pkg::BIT_EP_BASE+2*udi_pkg::NUM_EP] = '0;

  // one receive and one transmit bit per endpoint
  genvar ge;
  generate
    for (ge = 0; ge < udi_pkg::NUM_EP; ge++) begin : g_ep
      assign set_vec[udi_pkg::BIT_EP_BASE + 2*ge] = ep_receive_evt[ge];
      assign set_vec[udi_pkg::BIT_EP_BASE + 2*ge + 1] = ep_transmit_evt[ge];
    end
  endgenerate

  // status next value
  // w1c clear loses to a set in the same cycle
  wire [udi_pkg::STAT_W-1:0] status_clr = wr_status ? wbits : '0;
  wire [udi_pkg::STAT_W-1:0] status_kept = (int_status_r & ~status_clr) | set_vec;
  wire [udi_pkg::STAT_W-1:0] status_after_reset =
    udi_pkg::STAT_W'(1) << udi_pkg::BIT_BUS_RESET;
  assign int_status_nxt = (bus_reset_evt ? status_after_reset : status_kept)
                          & udi_pkg::STAT_IMPL;

  // mask and endpoint select next values
  wire [udi_pkg::DMA_MASK_W-1:0] mask_lanes = strb_bits[udi_pkg::DMA_MASK_W-1:0];
  wire [udi_pkg::DMA_MASK_W-1:0] mask_written =
    (dma_irq_mask_r & ~mask_lanes) | (w_data_r[udi_pkg::DMA_MASK_W-1:0] & mask_lanes);
  assign dma_irq_mask_nxt = bus_reset_evt ? udi_pkg::DMA_MASK_RESET :
                            wr_mask ? (mask_written & udi_pkg::DMA_MASK_IMPL) :
                            dma_irq_mask_r;

  wire epsel_lane = w_strb_r[0];
  assign dma_endpoint_select_nxt =
    bus_reset_evt ? udi_pkg::EPSEL_RESET :
    (wr_epsel && epsel_lane) ? (w_data_r[udi_pkg::EPSEL_W-1:0] & udi_pkg::EPSEL_IMPL) :
    dma_endpoint_select_r;

  // decoded selection from the next value, so outputs track the register
  wire [udi_pkg::EPSEL_NUM_W-1:0] ep_num_nxt =
    dma_endpoint_select_nxt[udi_pkg::EPSEL_NUM_LSB +: udi_pkg::EPSEL_NUM_W];
  wire dir_nxt = dma_endpoint_select_nxt[udi_pkg::EPSEL_DIR_BIT];
  wire [udi_pkg::NUM_EP-1:0] ep_onehot = udi_pkg::NUM_EP'(1) << ep_num_nxt;

  // alert status
  // clash between dma endpoint and the index endpoint is flagged, not blocked
  wire clash = dma_active & (ep_index_number == dma_ep_number);
  logic [udi_pkg::ALERT_W-1:0] alert_set;
  assign alert_set[udi_pkg::ALERT_CLASH] = clash & ~clash_prev_r;
  assign alert_set[udi_pkg::ALERT_BUS_RESET] = bus_reset_evt;
  wire alert_rd_clr = ar_hs & rd_alert; // a read clears
  assign alert_status_nxt = (alert_rd_clr ? udi_pkg::ALERT_RESET : alert_status_r)
                            | alert_set;
  assign alert_mask_nxt = (wr_amask && w_strb_r[0]) ? w_data_r[udi_pkg::ALERT_W-1:0]
                                                      : alert_mask_r;

  // read data mux
  logic [udi_pkg::AXI_DW-1:0] rd_data; // selected register
  assign rd_data =
    rd_status ? int_status_r :
    rd_mask ? {{(udi_pkg::AXI_DW-udi_pkg::DMA_MASK_W){1'b0}}, dma_irq_mask_r} :
    rd_epsel ? {{(udi_pkg::AXI_DW-udi_pkg::EPSEL_W){1'b0}}, dma_endpoint_select_r} :
    rd_alert ? {{(udi_pkg::AXI_DW-udi_pkg::ALERT_W){1'b0}}, alert_status_r} :
    rd_amask ? {{(udi_pkg::AXI_DW-udi_pkg::ALERT_W){1'b0}}, alert_mask_r} :
    '0;

  // register storage
  // status, masks and select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_r <= udi_pkg::STAT_RESET;
      dma_irq_mask_r <= udi_pkg::DMA_MASK_RESET;
      dma_endpoint_select_r <= udi_pkg::EPSEL_RESET;
      alert_status_r <= udi_pkg::ALERT_RESET;
      alert_mask_r <= udi_pkg::ALERT_RESET;
    end else begin
      int_status_r <= int_status_nxt;
      dma_irq_mask_r <= dma_irq_mask_nxt;
      dma_endpoint_select_r <= dma_endpoint_select_nxt;
      alert_status_r <= alert_status_nxt;
      alert_mask_r <= alert_mask_nxt;
    end
  end

  // edge history for event detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_masked_prev_r <= '0;
      hs_mode_prev_r <= 1'b0;
      clash_prev_r <= 1'b0;
    end else begin
      dma_masked_prev_r <= dma_masked;
      hs_mode_prev_r <= hs_mode;
      clash_prev_r <= clash;
    end
  end

  // registered outputs, in step with the registers they reflect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_out <= 1'b0;
      alert_irq <= 1'b0;
      dma_ep_number <= '0;
      dma_direction <= 1'b0;
      dma_receive_buf_sel <= '0;
      dma_transmit_buf_sel <= '0;
    end else begin
      irq_out <= |int_status_nxt;
      alert_irq <= |(alert_status_nxt & alert_mask_nxt);
      dma_ep_number <= ep_num_nxt;
      dma_direction <= dir_nxt;
      dma_receive_buf_sel <= dir_nxt ? '0 : ep_onehot;
      dma_transmit_buf_sel <= dir_nxt ? ep_onehot : '0;
    end
  end

  // write channels
  // address and data are taken in either order, then held until the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      s_axi_awready <= 1'b1;
    end else if (aw_hs) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      aw_full_r <= aw_full_r & ~wr_fire;
      s_axi_awready <= s_axi_awready | b_hs; // reopen after response
    end
  end

  // data channel hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_wready <= 1'b1;
    end else if (w_hs) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      w_full_r <= w_full_r & ~wr_fire;
      s_axi_wready <= s_axi_wready | b_hs;
    end
  end

  // write response, one cycle after the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= udi_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? udi_pkg::RESP_OKAY : udi_pkg::RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  // data captured at the address handshake, answered the next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= udi_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? udi_pkg::RESP_OKAY : udi_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // protection bits carry no meaning here
  wire prot_unused = ^{s_axi_awprot, s_axi_arprot};

endmodule // udi_irq_dma_sel
`default_nettype wire

/* test/udi_irq_dma_sel_props.sv */
`timescale 1ns/10ps
`default_nettype none
// port-level checks
module udi_irq_dma_sel_props #(
  parameter int FS_CYCLES = 25000,
  parameter int HS_CYCLES = 3125
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic bus_reset_evt,
  input wire logic sof_evt,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  input wire logic control_setup_evt,
  input wire logic [udi_pkg::NUM_EP-1:0] ep_transmit_evt,
  input wire logic [udi_pkg::NUM_EP-1:0] ep_receive_evt,
  input wire logic irq_out,
  input wire logic [udi_pkg::EPSEL_NUM_W-1:0] dma_ep_number,
  input wire logic dma_direction,
  input wire logic [udi_pkg::NUM_EP-1:0] dma_receive_buf_sel,
  input wire logic [udi_pkg::NUM_EP-1:0] dma_transmit_buf_sel
);
  // any pulse other than bus reset that must land in a status bit
  wire logic any_evt = sof_evt | suspend_evt | resume_evt | control_setup_evt
    | (|ep_transmit_evt) | (|ep_receive_evt);
  // both buffer selects merged
  wire logic [7:0] any_sel = dma_receive_buf_sel | dma_transmit_buf_sel;
  // no pending write can clear a status bit
  wire logic wr_idle = s_axi_awready & s_axi_wready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  evt_sets_irq_a: assert property (any_evt |=> irq_out)
    else $error("event did not raise irq");
  irq_holds_a: assert property (irq_out && wr_idle |=> irq_out)
    else $error("irq dropped without a clear");
  bus_reset_flag_irq_a: assert property (bus_reset_evt |=> irq_out)
    else $error("bus reset not reported");
  bus_reset_flag_sel_a: assert property (bus_reset_evt |=> dma_ep_number == 3'h0 && !dma_direction)
    else $error("select kept over bus reset");
  dir_sel_a: assert property ((dma_direction ? dma_receive_buf_sel : dma_transmit_buf_sel) == 8'h00)
    else $error("wrong buffer side selected");
  ep_onehot_a: assert property (any_sel != 8'h00 |-> any_sel == (8'h01 << dma_ep_number))
    else $error("buffer select not the chosen endpoint");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property (bus_reset_evt);
  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
endmodule // udi_irq_dma_sel_props
bind udi_irq_dma_sel udi_irq_dma_sel_props #(.FS_CYCLES(FS_CYCLES), .HS_CYCLES(HS_CYCLES))
  u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .bus_reset_evt, .sof_evt,
  .suspend_evt, .resume_evt, .control_setup_evt, .ep_transmit_evt, .ep_receive_evt, .irq_out,
  .dma_ep_number, .dma_direction, .dma_receive_buf_sel, .dma_transmit_buf_sel);
`default_nettype wire

/* test/udi_mcu_model.sv */
`timescale 1ns/10ps
`default_nettype none
// microcontroller side of the register bus
module udi_mcu_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
  end
  // write: call after a rising edge; each valid drops at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // read: data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule // udi_mcu_model
`default_nettype wire

/* test/usb_dev_irq_dma_select_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module usb_dev_irq_dma_select_tb_top;
  localparam int HS_C = 300; // shortened microframe count
  localparam logic [7:0] ST = udi_pkg::OFS_INT_STATUS;
  localparam logic [1:0] OK = udi_pkg::RESP_OKAY;
  localparam logic [7:0] MK = udi_pkg::OFS_DMA_MASK;
  localparam logic [7:0] EP = udi_pkg::OFS_DMA_EP_SEL;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, ep_index_number, dma_ep_number;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hs_mode, dma_active;
  logic bus_reset_evt, sof_evt, suspend_evt, resume_evt, control_setup_evt;
  logic irq_out, dma_direction, alert_irq;
  logic [7:0] ep_transmit_evt, ep_receive_evt, dma_receive_buf_sel, dma_transmit_buf_sel;
  logic [15:0] dma_reason_flags;
  logic [20:0] evts; // all event pulses in one word
  int fails = 0;
  int n_tests = 0;
  assign {ep_transmit_evt, ep_receive_evt, control_setup_evt, resume_evt, suspend_evt,
    sof_evt, bus_reset_evt} = evts;
  always #20 aclk = ~aclk; // 25 MHz
  udi_irq_dma_sel #(.FS_CYCLES(2000), .HS_CYCLES(HS_C)) uut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bus_reset_evt, .sof_evt, .suspend_evt, .resume_evt, .hs_mode,
    .control_setup_evt, .ep_transmit_evt, .ep_receive_evt, .dma_reason_flags, .dma_active,
    .ep_index_number, .irq_out, .alert_irq, .dma_ep_number, .dma_direction,
    .dma_receive_buf_sel, .dma_transmit_buf_sel);
  udi_mcu_model mcu (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bus wrappers, each starts on a rising edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    mcu.rd(a, d, r);
    chk(d & m, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge aclk);
    mcu.wr(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // one-cycle event pulse
  task automatic fire(input logic [20:0] v);
    @(posedge aclk);
    evts <= v;
    @(posedge aclk);
    evts <= '0;
  endtask
  // dma select outputs as one word
  task automatic selc(input logic [19:0] e);
    chk({12'h0, dma_ep_number, dma_direction, dma_receive_buf_sel, dma_transmit_buf_sel},
      {12'h0, e});
  endtask
  // irq level, looked at off the edge
  task automatic irqc(input logic e);
    @(negedge aclk);
    chk({31'h0, irq_out}, {31'h0, e});
  endtask
  // status bit expected for event line i
  function automatic logic [31:0] exp_bit(input int i);
    if (i == 1) return 32'h2;
    if (i < 4) return 32'h1 << (i + 1);
    if (i == 4) return 32'h100;
    if (i < 13) return 32'h1 << (2 * i);
    return 32'h1 << (2 * i - 15);
  endfunction
  task automatic t_regs();
    rdc(ST, '1, 32'h0, OK);
    rdc(MK, '1, 32'h0, OK);
    wrc(MK, 32'hffff_ffff, OK);
    rdc(MK, '1, 32'h1ffe, OK);
    wrc(EP, 32'hff, OK);
    rdc(EP, '1, 32'h0f, OK);
    selc({3'h7, 1'b1, 8'h00, 8'h80});
    wrc(EP, 32'h06, OK);
    selc({3'h3, 1'b0, 8'h08, 8'h00});
    wrc(8'h40, 32'h1, udi_pkg::RESP_SLVERR);
    rdc(8'h40, '1, 32'h0, udi_pkg::RESP_SLVERR);
    wrc(EP, 32'h0e, OK);
    $display("test regs done");
  endtask
  task automatic t_bus_reset_flag();
    fire(21'h100);
    fire(21'h1);
    rdc(ST, '1, 32'h1, OK);
    rdc(MK, '1, 32'h0, OK);
    rdc(EP, '1, 32'h0, OK);
    wrc(udi_pkg::OFS_ALERT_MASK, 32'h2, OK);
    chk({31'h0, alert_irq}, 32'h1);
    rdc(udi_pkg::OFS_ALERT_STATUS, '1, 32'h2, OK);
    chk({31'h0, alert_irq}, 32'h0);
    wrc(ST, 32'h1, OK);
    irqc(1'b0);
    $display("test bus reset done");
  endtask
  task automatic t_events();
    for (int i = 1; i < 21; i++) begin
      fire(21'h1 << i);
      rdc(ST, ~32'h4, exp_bit(i), OK);
      irqc(1'b1);
      wrc(ST, exp_bit(i) | 32'h4, OK);
      irqc(1'b0);
    end
    fire(21'h18);
    wrc(ST, 32'h10, OK);
    rdc(ST, ~32'h4, 32'h100, OK);
    wrc(ST, 32'h104, OK);
    $display("test events done");
  endtask
  task automatic t_dma();
    wrc(MK, 32'h2, OK);
    dma_reason_flags <= 16'h0010;
    dma_active <= 1'b1;
    rdc(ST, ~32'h4, 32'h0, OK);
    dma_reason_flags <= 16'h0012;
    rdc(ST, ~32'h4, 32'h40, OK);
    dma_reason_flags <= 16'h0000;
    dma_active <= 1'b0;
    wrc(ST, 32'h44, OK);
    irqc(1'b0);
    $display("test dma summary done");
  endtask
  task automatic t_hs();
    @(posedge aclk);
    hs_mode <= 1'b1;
    evts <= 21'h4;
    @(posedge aclk);
    evts <= '0;
    hs_mode <= 1'b0;
    rdc(ST, ~32'h4, 32'h8, OK);
    wrc(ST, 32'h2c, OK);
    hs_mode <= 1'b1;
    rdc(ST, ~32'h4, 32'h20, OK);
    wrc(ST, 32'h24, OK);
    $display("test speed change done");
  endtask
  task automatic t_pseudo_frame_flag();
    time t0;
    int n;
    fire(21'h2);
    t0 = $time;
    repeat (4) @(posedge aclk);
    wrc(ST, 32'hffff_ffff, OK);
    irqc(1'b0);
    for (n = 0; n < 400 && irq_out !== 1'b1; n++) @(negedge aclk);
    n = int'(($time - t0) / 40);
    chk({31'h0, n >= HS_C - 2 && n <= HS_C + 4}, 32'h1);
    rdc(ST, '1, 32'h4, OK);
    $display("test pseudo frame done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence; index register kept off every dma endpoint used
  initial begin
    evts = '0;
    hs_mode = 1'b0;
    dma_reason_flags = 16'h0;
    dma_active = 1'b0;
    ep_index_number = 3'h1;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_bus_reset_flag();
    t_events();
    t_dma();
    t_hs();
    t_pseudo_frame_flag();
    wrap_up();
  end
  // hang guard
  initial begin
    #800000;
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule // usb_dev_irq_dma_select_tb_top
`default_nettype wire
